// ### core/radio_core_deep_sleep_ctrl.sv
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/100ps
module radio_core_deep_sleep_ctrl
  import sleep_ctrl_pkg::*;
#(
  parameter int LP_DIV = LP_DIV_DEF
) (
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic [31:0]                 hrdata,
  output logic                        hresp,
  input  wire logic                   ext_wake_req,
  output logic                        irq,
  output logic                        low_power_wake_interrupt,
  output logic                        deep_sleep_active,
  output logic                        counter_correction_pulse,
  output logic [FINE_CORR_W-1:0]      fine_phase_correction
);

  // Divider must be able to count to its own terminal value
  if (LP_DIV < 2 || LP_DIV > 65535) begin : g_div_range
    $error("LP_DIV out of range");
  end

  localparam logic [15:0] DIV_LAST = 16'(LP_DIV - 1);

  typedef struct packed {
    sleep_state_type             state;
    logic [31:0]                 addr_low_bits;
    logic [ADDR_HIGH_W-1:0]      addr_high_bits;
    logic                        private_address_flag;
    logic [ET_START_W-1:0]       exchange_table_start;
    logic [RX_HEAD_W-1:0]        rx_list_head;
    logic                        external_wake_disable;
    logic                        sleep_req;
    logic                        software_wake_request;
    logic [IRQ_EN_W-1:0]         wake_irq_enable;
    logic [31:0]                 programmed_sleep_cycles;
    logic [31:0]                 measured_sleep_cycles;
    logic [EXT_DELAY_W-1:0]      external_wake_irq_delay;
    logic [ASSERT_LEAD_W-1:0]    wake_irq_assert_lead;
    logic [DEASSERT_LEAD_W-1:0]  wake_irq_deassert_lead;
    logic [FINE_CORR_W-1:0]      fine_phase_correction;
    logic [EVT_W-1:0]            evt_status;
    logic [EVT_W-1:0]            evt_mask;
    logic [15:0]                 div_cnt;
    logic                        lp_tick;
    logic [EXT_DELAY_W-1:0]      ext_hold_cnt;
    logic                        lp_irq;
    logic                        corr_pulse;
    logic                        dp_write;
    reg_index_type               dp_index;
    logic [31:0]                 rdata;
    logic                        irq;
  } state_type;

  state_type s_r;
  state_type s_nxt;

  // Address decode, shared by the read path and the write path
  function automatic reg_index_type reg_index(input logic [31:0] a);
    case (a)
      OFS_ADDR_LOW:   reg_index = IX_ADDR_LOW;
      OFS_ADDR_HIGH:  reg_index = IX_ADDR_HIGH;
      OFS_POINTERS:   reg_index = IX_POINTERS;
      OFS_SLEEP_CTRL: reg_index = IX_SLEEP_CTRL;
      OFS_SLEEP_TIME: reg_index = IX_SLEEP_TIME;
      OFS_SLEEP_DUR:  reg_index = IX_SLEEP_DUR;
      OFS_IRQ_TIMING: reg_index = IX_IRQ_TIMING;
      OFS_FINE_CORR:  reg_index = IX_FINE_CORR;
      OFS_EVT_STATUS: reg_index = IX_EVT_STATUS;
      OFS_EVT_MASK:   reg_index = IX_EVT_MASK;
      default:        reg_index = IX_NONE;
    endcase
  endfunction

  // Read word assembly; unmapped words and reserved bits read zero
  function automatic logic [31:0] read_word(input reg_index_type ix, input state_type s);
    logic [31:0] w;
    w = REG_RESET;
    case (ix)
      IX_ADDR_LOW:   w = s.addr_low_bits;
      IX_ADDR_HIGH: begin
        w[ADDR_HIGH_W-1:0] = s.addr_high_bits;
        w[PRIV_FLAG_BIT]   = s.private_address_flag;
      end
      IX_POINTERS: begin
        w[ET_START_LSB +: ET_START_W] = s.exchange_table_start;
        w[RX_HEAD_W-1:0]              = s.rx_list_head;
      end
      IX_SLEEP_CTRL: begin
        w[EXT_DIS_BIT]    = s.external_wake_disable;
        w[SLEEP_STAT_BIT] = (s.state == ST_SLEEP);
        w[SOFT_WAKE_BIT]  = s.software_wake_request;
        w[SLEEP_REQ_BIT]  = s.sleep_req;
        w[IRQ_EN_W-1:0]   = s.wake_irq_enable;
      end
      IX_SLEEP_TIME: w = s.programmed_sleep_cycles;
      IX_SLEEP_DUR:  w = s.measured_sleep_cycles;
      IX_IRQ_TIMING: begin
        w[EXT_DELAY_LSB +: EXT_DELAY_W]     = s.external_wake_irq_delay;
        w[ASSERT_LEAD_LSB +: ASSERT_LEAD_W] = s.wake_irq_assert_lead;
        w[DEASSERT_LEAD_W-1:0]              = s.wake_irq_deassert_lead;
      end
      IX_FINE_CORR:  w[FINE_CORR_W-1:0] = s.fine_phase_correction;
      IX_EVT_STATUS: w[EVT_W-1:0] = s.evt_status;
      IX_EVT_MASK:   w[EVT_W-1:0] = s.evt_mask;
      default:       w = REG_RESET;
    endcase
    read_word = w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  logic        bus_take;
  logic        wake_soft;
  logic        wake_ext;
  logic        wake_timer;
  logic [31:0] dur_inc;
  logic [31:0] remaining;
  logic        in_window;
  logic [EVT_W-1:0] evt_set;

  always_comb begin
    s_nxt     = s_r;
    evt_set   = '0;
    bus_take  = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    dur_inc   = s_r.measured_sleep_cycles + 32'h0000_0001;
    remaining = (s_r.programmed_sleep_cycles >= s_r.measured_sleep_cycles) ?
                s_r.programmed_sleep_cycles - s_r.measured_sleep_cycles : REG_RESET;
    wake_soft  = (s_r.state == ST_SLEEP) && s_r.software_wake_request;
    wake_ext   = (s_r.state == ST_SLEEP) && ext_wake_req && !s_r.external_wake_disable;
    wake_timer = (s_r.state == ST_SLEEP) && s_r.lp_tick
                 && (dur_inc >= s_r.programmed_sleep_cycles);
    s_nxt.corr_pulse = 1'b0;

    // Low-power rate tick from the system clock
    if (s_r.div_cnt == DIV_LAST) begin
      s_nxt.div_cnt = '0;
      s_nxt.lp_tick = 1'b1;
    end else begin
      s_nxt.div_cnt = s_r.div_cnt + 16'h0001;
      s_nxt.lp_tick = 1'b0;
    end

    // Data phase of a write; zero wait states so hwdata is valid now
    if (s_r.dp_write) begin
      case (s_r.dp_index)
        IX_ADDR_LOW: s_nxt.addr_low_bits = hwdata;
        IX_ADDR_HIGH: begin
          s_nxt.addr_high_bits       = hwdata[ADDR_HIGH_W-1:0];
          s_nxt.private_address_flag = hwdata[PRIV_FLAG_BIT];
        end
        IX_POINTERS: begin
          s_nxt.exchange_table_start = hwdata[ET_START_LSB +: ET_START_W];
          s_nxt.rx_list_head         = hwdata[RX_HEAD_W-1:0];
        end
        IX_SLEEP_CTRL: begin
          s_nxt.external_wake_disable = hwdata[EXT_DIS_BIT];
          s_nxt.wake_irq_enable       = hwdata[IRQ_EN_W-1:0];
          // Writing 0 to the action bits never cancels anything
          if (hwdata[SLEEP_REQ_BIT]) begin
            s_nxt.sleep_req = 1'b1;
          end
          if (hwdata[SOFT_WAKE_BIT] && s_r.state == ST_SLEEP) begin
            s_nxt.software_wake_request = 1'b1;
          end
          // Counters restart only while awake and not about to enter sleep
          if (hwdata[CORR_EN_BIT] && s_r.state == ST_ACTIVE && !s_r.sleep_req) begin
            s_nxt.corr_pulse = 1'b1;
          end
        end
        IX_SLEEP_TIME: s_nxt.programmed_sleep_cycles = hwdata;
        IX_IRQ_TIMING: begin
          s_nxt.external_wake_irq_delay = hwdata[EXT_DELAY_LSB +: EXT_DELAY_W];
          s_nxt.wake_irq_assert_lead    = hwdata[ASSERT_LEAD_LSB +: ASSERT_LEAD_W];
          s_nxt.wake_irq_deassert_lead  = hwdata[DEASSERT_LEAD_W-1:0];
        end
        IX_FINE_CORR:  s_nxt.fine_phase_correction = hwdata[FINE_CORR_W-1:0];
        IX_EVT_STATUS: s_nxt.evt_status = s_r.evt_status & ~hwdata[EVT_W-1:0];
        IX_EVT_MASK:   s_nxt.evt_mask = hwdata[EVT_W-1:0];
        default: begin
        end
      endcase
    end

    // Sleep sequencer
    case (s_r.state)
      ST_ACTIVE: begin
        if (s_r.sleep_req) begin
          s_nxt.state                 = ST_SLEEP;
          s_nxt.measured_sleep_cycles = REG_RESET;
          evt_set[EVT_ENTERED]        = 1'b1;
        end
      end
      ST_SLEEP: begin
        if (s_r.lp_tick) begin
          s_nxt.measured_sleep_cycles = dur_inc;
        end
        // Any wake source ends the phase; status falling clears the request
        if (wake_soft || wake_ext || wake_timer) begin
          s_nxt.state                 = ST_ACTIVE;
          s_nxt.sleep_req             = 1'b0;
          s_nxt.software_wake_request = 1'b0;
          evt_set[EVT_WAKE_TMR]       = wake_timer;
          evt_set[EVT_WAKE_EXT]       = wake_ext;
          evt_set[EVT_WAKE_SOFT]      = wake_soft;
          if (wake_ext && s_r.wake_irq_enable[1]) begin
            s_nxt.ext_hold_cnt = s_r.external_wake_irq_delay;
          end
        end
      end
      default: s_nxt.state = ST_ACTIVE;
    endcase

    // External wake hold counts down in low-power cycles
    if (s_r.ext_hold_cnt != '0 && s_r.lp_tick && !(wake_ext && s_r.wake_irq_enable[1])) begin
      s_nxt.ext_hold_cnt = s_r.ext_hold_cnt - 11'h001;
    end

    // Timed window: up at assert lead, down at deassert lead before expiry
    in_window = (s_r.state == ST_SLEEP) && s_r.wake_irq_enable[0]
                && (remaining <= 32'(s_r.wake_irq_assert_lead))
                && (remaining >  32'(s_r.wake_irq_deassert_lead));
    s_nxt.lp_irq = in_window || (s_nxt.ext_hold_cnt != '0);

    // Events set after the clear so a same-cycle event is kept
    s_nxt.evt_status = s_nxt.evt_status | evt_set;
    s_nxt.irq        = |(s_nxt.evt_status & s_nxt.evt_mask);

    // Address phase; read data is built now so it is ready in the data phase
    s_nxt.dp_write = bus_take && hwrite;
    s_nxt.dp_index = bus_take ? reg_index(haddr) : IX_NONE;
    // Built from the next state so a write in its data phase right now is seen
    s_nxt.rdata    = (bus_take && !hwrite) ? read_word(reg_index(haddr), s_nxt) : REG_RESET;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from flip-flops, except hreadyout and hresp, which are tied constant
  assign hreadyout                = 1'b1;
  assign hresp                    = HRESP_OKAY;
  assign hrdata                   = s_r.rdata;
  assign irq                      = s_r.irq;
  assign low_power_wake_interrupt = s_r.lp_irq;
  assign deep_sleep_active        = (s_r.state == ST_SLEEP);
  assign counter_correction_pulse = s_r.corr_pulse;
  assign fine_phase_correction    = s_r.fine_phase_correction;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_sleep_entry_clear: assert property (
    (s_r.state == ST_ACTIVE && s_r.sleep_req) |=> (s_r.state == ST_SLEEP && s_r.measured_sleep_cycles == 32'h0))
    else $error("sleep entry did not clear duration");

  a_duration_counts: assert property (
    (s_r.state == ST_SLEEP && s_r.lp_tick) |=> (s_r.measured_sleep_cycles == $past(s_r.measured_sleep_cycles) + 32'h1))
    else $error("duration did not advance on tick");

  a_timer_expiry_wake: assert property (
    (s_r.state == ST_SLEEP && s_r.lp_tick
     && s_r.measured_sleep_cycles + 32'h1 >= s_r.programmed_sleep_cycles) |=> !deep_sleep_active)
    else $error("sleep timer expiry did not wake");

  a_ext_wake_enabled: assert property (
    (s_r.state == ST_SLEEP && ext_wake_req && !s_r.external_wake_disable) |=> !deep_sleep_active)
    else $error("enabled external wake ignored");

  a_ext_wake_masked: assert property (
    (s_r.state == ST_SLEEP && s_r.external_wake_disable && !s_r.lp_tick && !s_r.software_wake_request)
    |=> deep_sleep_active)
    else $error("disabled external wake acted");

  a_soft_wake_clear: assert property (
    s_r.software_wake_request |=> (!s_r.software_wake_request && !deep_sleep_active))
    else $error("software wake not performed or not cleared");

  a_req_clears_exit: assert property (
    $fell(deep_sleep_active) |-> !s_r.sleep_req)
    else $error("sleep request survived wake");

  a_corr_single_pulse: assert property (
    counter_correction_pulse |-> (!deep_sleep_active ##1 !counter_correction_pulse))
    else $error("correction pulse malformed");

  a_lead_window: assert property (
    (deep_sleep_active && s_r.ext_hold_cnt == '0 && s_r.state == ST_SLEEP
     && $stable(s_r.programmed_sleep_cycles)
     && s_r.programmed_sleep_cycles - s_r.measured_sleep_cycles <= 32'(s_r.wake_irq_deassert_lead)
     && s_r.programmed_sleep_cycles >= s_r.measured_sleep_cycles)
    |=> !low_power_wake_interrupt || s_r.ext_hold_cnt != '0)
    else $error("wake interrupt high inside deassert lead");

  a_ext_hold_irq: assert property (
    (!wake_ext && (s_r.ext_hold_cnt > EXT_DELAY_W'(1) || (s_r.ext_hold_cnt != '0 && !s_r.lp_tick)))
    |=> low_power_wake_interrupt)
    else $error("wake interrupt low during external hold");

  // Register writes land at the end of their data phase
  a_addr_low_write: assert property (
    (s_r.dp_write && s_r.dp_index == IX_ADDR_LOW)
    |=> (s_r.addr_low_bits == $past(hwdata)))
    else $error("low address word not written");

  a_priv_flag_write: assert property (
    (s_r.dp_write && s_r.dp_index == IX_ADDR_HIGH)
    |=> (s_r.private_address_flag == $past(hwdata[PRIV_FLAG_BIT])))
    else $error("address type flag not written");

  // Action bits refused in the wrong state; software wake taken at once while asleep
  a_soft_wake_awake: assert property (
    (s_r.dp_write && s_r.dp_index == IX_SLEEP_CTRL && s_r.state == ST_ACTIVE)
    |=> !s_r.software_wake_request)
    else $error("software wake kept while awake");

  a_corr_asleep: assert property (
    (s_r.dp_write && s_r.dp_index == IX_SLEEP_CTRL && s_r.state == ST_SLEEP)
    |=> !counter_correction_pulse)
    else $error("correction pulse while asleep");

  a_soft_wake_first: assert property (
    (s_r.state == ST_SLEEP && s_r.software_wake_request)
    |=> (s_r.state == ST_ACTIVE && s_r.evt_status[EVT_WAKE_SOFT]))
    else $error("software wake did not end sleep");

  // Wake interrupt edges around the timed window and the external hold
  a_window_rise: assert property (
    (s_r.state == ST_SLEEP && s_r.wake_irq_enable[0]
     && s_r.programmed_sleep_cycles >= s_r.measured_sleep_cycles
     && s_r.programmed_sleep_cycles - s_r.measured_sleep_cycles <= 32'(s_r.wake_irq_assert_lead)
     && s_r.programmed_sleep_cycles - s_r.measured_sleep_cycles > 32'(s_r.wake_irq_deassert_lead))
    |=> low_power_wake_interrupt)
    else $error("wake interrupt low inside assert lead");

  a_ext_hold_end: assert property (
    (s_r.state == ST_ACTIVE && s_r.ext_hold_cnt == EXT_DELAY_W'(1) && s_r.lp_tick)
    |=> !low_power_wake_interrupt)
    else $error("wake interrupt outlived external hold");

endmodule // radio_core_deep_sleep_ctrl

// ### core/sleep_ctrl_pkg.sv
package sleep_ctrl_pkg;

  // Register byte addresses
  localparam logic [31:0] OFS_ADDR_LOW   = 32'h4000_0024;
  localparam logic [31:0] OFS_ADDR_HIGH  = 32'h4000_0028;
  localparam logic [31:0] OFS_POINTERS   = 32'h4000_002c;
  localparam logic [31:0] OFS_SLEEP_CTRL = 32'h4000_0030;
  localparam logic [31:0] OFS_SLEEP_TIME = 32'h4000_0034;
  localparam logic [31:0] OFS_SLEEP_DUR  = 32'h4000_0038;
  localparam logic [31:0] OFS_IRQ_TIMING = 32'h4000_003c;
  localparam logic [31:0] OFS_FINE_CORR  = 32'h4000_0040;
  localparam logic [31:0] OFS_EVT_STATUS = 32'h4000_0048;
  localparam logic [31:0] OFS_EVT_MASK   = 32'h4000_004c;

  // Field positions
  localparam int PRIV_FLAG_BIT   = 16;
  localparam int ET_START_LSB    = 16;
  localparam int EXT_DIS_BIT     = 31;
  localparam int SLEEP_STAT_BIT  = 15;
  localparam int SOFT_WAKE_BIT   = 4;
  localparam int CORR_EN_BIT     = 3;
  localparam int SLEEP_REQ_BIT   = 2;
  localparam int EXT_DELAY_LSB   = 21;
  localparam int ASSERT_LEAD_LSB = 10;

  // Field widths
  localparam int ADDR_HIGH_W     = 16;
  localparam int ET_START_W      = 16;
  localparam int RX_HEAD_W       = 15;
  localparam int IRQ_EN_W        = 2;
  localparam int EXT_DELAY_W     = 11;
  localparam int ASSERT_LEAD_W   = 11;
  localparam int DEASSERT_LEAD_W = 10;
  localparam int FINE_CORR_W     = 10;
  localparam int EVT_W           = 4;

  // Event bit positions in status and mask
  localparam int EVT_ENTERED   = 0;
  localparam int EVT_WAKE_TMR  = 1;
  localparam int EVT_WAKE_EXT  = 2;
  localparam int EVT_WAKE_SOFT = 3;

  // Reset value shared by every register
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // Timing: system clock and low-power tick rate
  localparam int SYS_CLK_HZ = 25_000_000;
  localparam int LP_CLK_HZ  = 32_768;
  localparam int LP_DIV_DEF = SYS_CLK_HZ / LP_CLK_HZ;

  // Bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic       HRESP_OKAY    = 1'h0;

  typedef enum logic {ST_ACTIVE, ST_SLEEP} sleep_state_type;

  typedef enum logic [3:0] {
    IX_NONE, IX_ADDR_LOW, IX_ADDR_HIGH, IX_POINTERS, IX_SLEEP_CTRL, IX_SLEEP_TIME,
    IX_SLEEP_DUR, IX_IRQ_TIMING, IX_FINE_CORR, IX_EVT_STATUS, IX_EVT_MASK
  } reg_index_type;

endpackage

// ### dv/tb_radio_core_deep_sleep_ctrl.sv
`timescale 1ns/100ps
// One comparison: counts it, reports a mismatch at once
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module tb_radio_core_deep_sleep_ctrl;
  import sleep_ctrl_pkg::*;

  // Short tick so a sleep phase lasts tens of cycles, not thousands
  localparam int LP_DIV_SIM = 4;

  logic                   sys_clk;
  logic                   reset;
  logic                   hsel;
  logic [31:0]            haddr;
  logic [1:0]             htrans;
  logic                   hwrite;
  logic [2:0]             hsize;
  logic [31:0]            hwdata;
  logic                   hreadyout;
  logic [31:0]            hrdata;
  logic                   hresp;
  logic                   ext_wake_req;
  logic                   irq;
  logic                   low_power_wake_interrupt;
  logic                   deep_sleep_active;
  logic                   counter_correction_pulse;
  logic [FINE_CORR_W-1:0] fine_phase_correction;
  int                     n_mismatch;
  int                     n_tests;
  int                     win_cnt;
  int                     pulse_cnt;
  logic [31:0]            rd;
  logic [31:0]            addrs [10];

  radio_core_deep_sleep_ctrl #(.LP_DIV(LP_DIV_SIM)) dut (
    .sys_clk                  (sys_clk),
    .reset                    (reset),
    .hsel                     (hsel),
    .haddr                    (haddr),
    .htrans                   (htrans),
    .hwrite                   (hwrite),
    .hsize                    (hsize),
    .hwdata                   (hwdata),
    .hready                   (hreadyout),
    .hreadyout                (hreadyout),
    .hrdata                   (hrdata),
    .hresp                    (hresp),
    .ext_wake_req             (ext_wake_req),
    .irq                      (irq),
    .low_power_wake_interrupt (low_power_wake_interrupt),
    .deep_sleep_active        (deep_sleep_active),
    .counter_correction_pulse (counter_correction_pulse),
    .fine_phase_correction    (fine_phase_correction)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock and watched-output counters, sampled mid-cycle so nothing races
  always #20 sys_clk = ~sys_clk;

  always @(negedge sys_clk) begin
    if (low_power_wake_interrupt === 1'b1) win_cnt++;
    if (counter_correction_pulse === 1'b1) pulse_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Single-word bus transfer; waits on hready, never on a fixed count
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rv);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rv = hrdata;
    `CHK("hresp", HRESP_OKAY, hresp)
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask

  task automatic chk_rd(input string nm, input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000, rd);
    `CHK(nm, e, rd)
  endtask

  // Bounded wait for the sleep flag to reach a level
  task automatic wait_sleep(input logic v);
    int i;
    i = 0;
    while (deep_sleep_active !== v && i < 300) begin
      @(posedge sys_clk);
      i++;
    end
    `CHK("deep_sleep_active", v, deep_sleep_active)
  endtask

  task automatic report_and_stop;
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: whole run is a few hundred cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    report_and_stop;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    sys_clk = 1'b0; reset = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
    hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; ext_wake_req = 1'b0;
    n_mismatch = 0; n_tests = 0; win_cnt = 0; pulse_cnt = 0;
    addrs = '{OFS_ADDR_LOW, OFS_ADDR_HIGH, OFS_POINTERS, OFS_SLEEP_CTRL, OFS_SLEEP_TIME,
              OFS_SLEEP_DUR, OFS_IRQ_TIMING, OFS_FINE_CORR, OFS_EVT_STATUS, OFS_EVT_MASK};
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    // Everything quiet and zero after reset
    `CHK("hreadyout", 1'b1, hreadyout)
    `CHK("irq", 1'b0, irq)
    `CHK("lp_wake_irq", 1'b0, low_power_wake_interrupt)
    `CHK("sleep_flag", 1'b0, deep_sleep_active)
    for (int k = 0; k < 10; k++) begin
      chk_rd("reset_value", addrs[k], REG_RESET);
    end

    // Plain storage registers, unused bits read back zero
    wr(OFS_ADDR_LOW, 32'ha5c3_1e96);
    chk_rd("addr_low", OFS_ADDR_LOW, 32'ha5c3_1e96);
    wr(OFS_ADDR_HIGH, 32'hffff_ffff);
    chk_rd("addr_high_priv", OFS_ADDR_HIGH, 32'h0001_ffff);
    wr(OFS_ADDR_HIGH, 32'h0000_1234);
    chk_rd("addr_high_pub", OFS_ADDR_HIGH, 32'h0000_1234);
    wr(OFS_POINTERS, 32'hffff_ffff);
    chk_rd("pointers", OFS_POINTERS, 32'hffff_7fff);
    wr(OFS_FINE_CORR, 32'h0000_03ff);
    chk_rd("fine_corr", OFS_FINE_CORR, 32'h0000_03ff);
    `CHK("fine_corr_port", 10'h3ff, fine_phase_correction)
    // Unmapped places ignore writes and read zero
    wr(32'h4000_0044, 32'hffff_ffff);
    chk_rd("unmapped_44", 32'h4000_0044, 32'h0000_0000);
    chk_rd("unmapped_20", 32'h4000_0020, 32'h0000_0000);
    // Soft wake written while awake is dropped; disable bit sticks
    wr(OFS_SLEEP_CTRL, 32'h8000_0013);
    chk_rd("ctrl_awake", OFS_SLEEP_CTRL, 32'h8000_0003);

    ////////////////////////////////////////////////////////////////////////
    // Timed sleep of 10 ticks, window leads 5 and 1, external hold 3
    wr(OFS_SLEEP_TIME, 32'h0000_000a);
    wr(OFS_IRQ_TIMING, 32'h0060_1401);
    win_cnt = 0;
    wr(OFS_SLEEP_CTRL, 32'h0000_0007);
    wait_sleep(1'b1);
    chk_rd("ctrl_asleep", OFS_SLEEP_CTRL, 32'h0000_8007);
    wait_sleep(1'b0);
    // Window spans remaining 5 down to 2: four ticks
    `CHK("wake_window", 4 * LP_DIV_SIM, win_cnt)
    chk_rd("duration", OFS_SLEEP_DUR, 32'h0000_000a);
    chk_rd("ctrl_woken", OFS_SLEEP_CTRL, 32'h0000_0003);
    chk_rd("evt_timer", OFS_EVT_STATUS, 32'h0000_0003);
    `CHK("irq_masked", 1'b0, irq)
    wr(OFS_EVT_MASK, 32'h0000_0002);
    repeat (2) @(posedge sys_clk);
    `CHK("irq_unmasked", 1'b1, irq)
    wr(OFS_EVT_STATUS, 32'h0000_0003);
    repeat (2) @(posedge sys_clk);
    `CHK("irq_cleared", 1'b0, irq)
    chk_rd("evt_cleared", OFS_EVT_STATUS, 32'h0000_0000);

    ////////////////////////////////////////////////////////////////////////
    // Software wake of a long sleep; correction while asleep is dropped
    wr(OFS_SLEEP_TIME, 32'h0000_03e8);
    wr(OFS_SLEEP_CTRL, 32'h0000_0007);
    wait_sleep(1'b1);
    pulse_cnt = 0;
    wr(OFS_SLEEP_CTRL, 32'h0000_000f);
    repeat (3) @(posedge sys_clk);
    `CHK("corr_asleep", 0, pulse_cnt)
    wr(OFS_SLEEP_CTRL, 32'h0000_0017);
    wait_sleep(1'b0);
    chk_rd("ctrl_soft", OFS_SLEEP_CTRL, 32'h0000_0003);
    chk_rd("evt_soft", OFS_EVT_STATUS, 32'h0000_0009);
    wr(OFS_EVT_STATUS, 32'h0000_000f);
    // One-cycle restart pulse after wake, bit reads zero
    pulse_cnt = 0;
    wr(OFS_SLEEP_CTRL, 32'h0000_000b);
    repeat (3) @(posedge sys_clk);
    `CHK("corr_pulse", 1, pulse_cnt)
    chk_rd("ctrl_corr", OFS_SLEEP_CTRL, 32'h0000_0003);

    ////////////////////////////////////////////////////////////////////////
    // External wake: ignored while disabled, then taken with its hold
    wr(OFS_SLEEP_CTRL, 32'h8000_0007);
    wait_sleep(1'b1);
    ext_wake_req <= 1'b1;
    repeat (10) @(posedge sys_clk);
    `CHK("ext_disabled", 1'b1, deep_sleep_active)
    ext_wake_req <= 1'b0;
    wr(OFS_SLEEP_CTRL, 32'h0000_0007);
    win_cnt = 0;
    ext_wake_req <= 1'b1;
    wait_sleep(1'b0);
    ext_wake_req <= 1'b0;
    repeat (20) @(posedge sys_clk);
    // Hold of 3 ticks, first tick at any phase of the divider
    `CHK("ext_hold", 1'b1, (win_cnt >= 2 * LP_DIV_SIM + 1 && win_cnt <= 3 * LP_DIV_SIM))
    `CHK("lp_irq_low", 1'b0, low_power_wake_interrupt)
    chk_rd("evt_ext", OFS_EVT_STATUS, 32'h0000_0005);
    report_and_stop;
  end

endmodule // tb_radio_core_deep_sleep_ctrl
